// File: verilog/scm_top.sv
// sine/cosine generator with complex multiplier, accumulators and output mux
// Summary of operation
// - upper 20 phase bits address the table giving 16-bit sine and cosine
// - table address covers one full turn, zero means zero radians
// - sine and cosine are clamped between 8001 and 7FFF
// - vector error stays below -90.2 dB of full scale
// - bypass low routes the phase word straight to the multiplier
// - bypass with 7FFF, 0, select 00 shows phase halves on outputs
// - real = cos*re - sin*im, imag = cos*im + sin*re
// - input registers load only while capture enable is low
// - shift select picks input bits 0-15, 1-16, 2-17 or 3-18
// - 33-bit products are registered before the accumulator
// - accumulate high adds feedback, low stores the product alone
// - result select maps product high, product low or auxiliary sum
// - format select low inverts output bit 19 for unsigned output
// - auxiliary accumulator sums shifter outputs under the same control
// - growth code gives growth bits 0 to 3 over both accumulators
// - peak hold low keeps the largest growth code seen
// - inputs are fractions, outputs have four integer bits
// - every datapath register runs on the one device clock
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
module scm_top
	import scm_pkg::*;
(
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	input  wire logic              i_clk_en,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [DATA_W-1:0] i_pwdata,
	output logic      [DATA_W-1:0] o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	input  wire logic [PHASE_W-1:0] i_phase_word,
	input  wire logic [IN_W-1:0]   i_real_in,
	input  wire logic [IN_W-1:0]   i_imag_in,
	input  wire logic              i_input_capture_en_n,
	input  wire logic              i_accumulate_en,
	output logic      [OUT_W-1:0]  o_real_result,
	output logic      [OUT_W-1:0]  o_imag_result,
	output logic      [GROW_W-1:0] o_growth_level
);

	// rounds the rotation result to 16 bits and clamps it symmetrically
	function automatic logic [TRIG_W-1:0] trig_round(input logic signed [CORDIC_W-1:0] v);
		logic signed [CORDIC_W-1:0] t;
		logic signed [CORDIC_W-1:0] lim;
		lim = $signed(CORDIC_W'(TRIG_POS_FS));
		// half an output step first, so the shift rounds to nearest
		t = (v + ($signed(CORDIC_W'(1'h1)) <<< (CORDIC_FRAC - 1))) >>> CORDIC_FRAC;
		if (t > lim) begin
			return TRIG_POS_FS;
		end
		if (t < -lim) begin
			return TRIG_NEG_FS;
		end
		return t[TRIG_W-1:0];
	endfunction

	// table lookup: address in 2^20 steps per turn, returns {sin, cos}
	function automatic logic [2*TRIG_W-1:0] sincos_of(input logic [LUT_ADDR_W-1:0] addr);
		logic signed [ANG_W-1:0]    z;
		logic signed [CORDIC_W-1:0] x;
		logic signed [CORDIC_W-1:0] y;
		logic signed [CORDIC_W-1:0] xt;
		logic                       flip;
		z = {addr, {(ANG_W-LUT_ADDR_W){1'b0}}};
		flip = z[ANG_W-1] ^ z[ANG_W-2];
		// fold the left half-plane onto the right by a half turn
		if (flip) begin
			z[ANG_W-1] = ~z[ANG_W-1];
		end
		x = CORDIC_X0;
		y = '0;
		for (int i = 0; i < CORDIC_ITER; i++) begin
			xt = x;
			if (!z[ANG_W-1]) begin
				x = x - (y >>> i);
				y = y + (xt >>> i);
				z = z - $signed(ATAN_TAB[i]);
			end else begin
				x = x + (y >>> i);
				y = y - (xt >>> i);
				z = z + $signed(ATAN_TAB[i]);
			end
		end
		if (flip) begin
			x = -x;
			y = -y;
		end
		return {trig_round(y), trig_round(x)};
	endfunction

	// input shifter
	function automatic logic [TRIG_W-1:0] shift_of(input logic [IN_W-1:0] v,
		input logic [1:0] sel);
		logic [IN_W-1:0] t;
		t = v >> sel;
		return t[TRIG_W-1:0];
	endfunction

	// growth bits above unity from the sign bit and the four bits below it
	function automatic logic [GROW_W-1:0] growth_of(input logic [4:0] t);
		if (t[4:1] == {4{t[0]}}) begin
			return 2'h0;
		end
		if (t[4:2] == {3{t[1]}}) begin
			return 2'h1;
		end
		if (t[4:3] == {2{t[2]}}) begin
			return 2'h2;
		end
		return 2'h3;
	endfunction

	function automatic logic [GROW_W-1:0] max2(input logic [GROW_W-1:0] a,
		input logic [GROW_W-1:0] b);
		return (a > b) ? a : b;
	endfunction

	// output multiplexer and number format
	function automatic logic [OUT_W-1:0] out_map(input logic [ACC_W-1:0] acc,
		input logic [AUX_W-1:0] aux, input logic [1:0] sel, input logic fmt);
		logic [OUT_W-1:0] r;
		case (sel)
			SEL_PROD_HI: r = acc[34:15];
			SEL_PROD_LO: r = {acc[34:31], 1'b0, acc[14:0]};
			SEL_AUX:     r = aux;
			default:     r = '0;
		endcase
		if (!fmt) begin
			r[OUT_W-1] = ~r[OUT_W-1];
		end
		return r;
	endfunction

	// register bus
	logic [CTRL_W-1:0] ctrl_r;
	logic [CTRL_W-1:0] ctrl_nxt;
	logic [DATA_W-1:0] prdata_r;
	logic [DATA_W-1:0] prdata_nxt;
	logic              hit_ctrl;
	logic              hit_stat;

	// datapath
	logic [PHASE_W-1:0]       phase_r;
	logic [PHASE_W-1:0]       phase_nxt;
	logic [IN_W-1:0]          rin_r;
	logic [IN_W-1:0]          rin_nxt;
	logic [IN_W-1:0]          iin_r;
	logic [IN_W-1:0]          iin_nxt;
	logic signed [TRIG_W-1:0] cos_r;
	logic signed [TRIG_W-1:0] cos_nxt;
	logic signed [TRIG_W-1:0] sin_r;
	logic signed [TRIG_W-1:0] sin_nxt;
	logic signed [TRIG_W-1:0] rsh_r;
	logic signed [TRIG_W-1:0] rsh_nxt;
	logic signed [TRIG_W-1:0] ish_r;
	logic signed [TRIG_W-1:0] ish_nxt;
	logic signed [PROD_W-1:0] mre_r;
	logic signed [PROD_W-1:0] mre_nxt;
	logic signed [PROD_W-1:0] mim_r;
	logic signed [PROD_W-1:0] mim_nxt;
	logic [TRIG_W-1:0]        are_in_r;
	logic [TRIG_W-1:0]        aim_in_r;
	logic [ACC_W-1:0]         acc_re_r;
	logic [ACC_W-1:0]         acc_re_nxt;
	logic [ACC_W-1:0]         acc_im_r;
	logic [ACC_W-1:0]         acc_im_nxt;
	logic [AUX_W-1:0]         aux_re_r;
	logic [AUX_W-1:0]         aux_re_nxt;
	logic [AUX_W-1:0]         aux_im_r;
	logic [AUX_W-1:0]         aux_im_nxt;
	logic [OUT_W-1:0]         out_re_r;
	logic [OUT_W-1:0]         out_re_nxt;
	logic [OUT_W-1:0]         out_im_r;
	logic [OUT_W-1:0]         out_im_nxt;
	logic [GROW_W-1:0]        grow_r;
	logic [GROW_W-1:0]        grow_nxt;
	logic [GROW_W-1:0]        grow_now;
	logic [2*TRIG_W-1:0]      trig;

	// zero-wait slave; a frozen clock enable stretches the access
	assign o_pready  = i_clk_en;
	assign hit_ctrl  = (i_paddr == CTRL_OFFS);
	assign hit_stat  = (i_paddr == STAT_OFFS);
	assign o_pslverr = i_psel & i_penable & ~(hit_ctrl | hit_stat);
	assign o_prdata  = prdata_r;

	always_comb begin
		ctrl_nxt   = ctrl_r;
		prdata_nxt = prdata_r;
		if (i_psel && i_penable && i_pwrite && hit_ctrl) begin
			ctrl_nxt = i_pwdata[CTRL_W-1:0];
		end
		// read data is fetched during the setup cycle
		if (i_psel && !i_penable) begin
			prdata_nxt = '0;
			if (hit_ctrl) begin
				prdata_nxt[CTRL_W-1:0] = ctrl_r;
			end
			if (hit_stat) begin
				prdata_nxt[STAT_GROW_LO +: GROW_W] = grow_r;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			ctrl_r   <= CTRL_RESET;
			prdata_r <= '0;
		end else if (i_clk_en) begin
			ctrl_r   <= ctrl_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// stage 1 phase and input capture, stage 2 trig and shift
	always_comb begin
		phase_nxt = i_phase_word;
		rin_nxt   = rin_r;
		iin_nxt   = iin_r;
		if (!i_input_capture_en_n) begin
			rin_nxt = i_real_in;
			iin_nxt = i_imag_in;
		end
		trig = sincos_of(phase_r[PHASE_W-1 -: LUT_ADDR_W]);
		if (!ctrl_r[CTRL_BYPASS_N]) begin
			sin_nxt = phase_r[PHASE_W-1 -: TRIG_W];
			cos_nxt = phase_r[TRIG_W-1:0];
		end else begin
			sin_nxt = trig[2*TRIG_W-1 -: TRIG_W];
			cos_nxt = trig[TRIG_W-1:0];
		end
		rsh_nxt = shift_of(rin_r, ctrl_r[CTRL_SHIFT_LO +: 2]);
		ish_nxt = shift_of(iin_r, ctrl_r[CTRL_SHIFT_LO +: 2]);
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			phase_r <= '0;
			rin_r   <= '0;
			iin_r   <= '0;
			sin_r   <= '0;
			cos_r   <= '0;
			rsh_r   <= '0;
			ish_r   <= '0;
		end else if (i_clk_en) begin
			phase_r <= phase_nxt;
			rin_r   <= rin_nxt;
			iin_r   <= iin_nxt;
			sin_r   <= sin_nxt;
			cos_r   <= cos_nxt;
			rsh_r   <= rsh_nxt;
			ish_r   <= ish_nxt;
		end
	end

	// stage 3 complex products, fractions with point below the sign
	always_comb begin
		mre_nxt = cos_r * rsh_r - sin_r * ish_r;
		mim_nxt = cos_r * ish_r + sin_r * rsh_r;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			mre_r    <= '0;
			mim_r    <= '0;
			are_in_r <= '0;
			aim_in_r <= '0;
		end else if (i_clk_en) begin
			mre_r    <= mre_nxt;
			mim_r    <= mim_nxt;
			are_in_r <= rsh_r;
			aim_in_r <= ish_r;
		end
	end

	// stage 4 accumulators, feedback zeroed when accumulate is low
	always_comb begin
		acc_re_nxt = {{(ACC_W-PROD_W){mre_r[PROD_W-1]}}, mre_r};
		acc_im_nxt = {{(ACC_W-PROD_W){mim_r[PROD_W-1]}}, mim_r};
		aux_re_nxt = {{(AUX_W-TRIG_W){are_in_r[TRIG_W-1]}}, are_in_r};
		aux_im_nxt = {{(AUX_W-TRIG_W){aim_in_r[TRIG_W-1]}}, aim_in_r};
		if (i_accumulate_en) begin
			acc_re_nxt = acc_re_nxt + acc_re_r;
			acc_im_nxt = acc_im_nxt + acc_im_r;
			aux_re_nxt = aux_re_nxt + aux_re_r;
			aux_im_nxt = aux_im_nxt + aux_im_r;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			acc_re_r <= '0;
			acc_im_r <= '0;
			aux_re_r <= '0;
			aux_im_r <= '0;
		end else if (i_clk_en) begin
			acc_re_r <= acc_re_nxt;
			acc_im_r <= acc_im_nxt;
			aux_re_r <= aux_re_nxt;
			aux_im_r <= aux_im_nxt;
		end
	end

	// stage 5 output mux and growth detect
	always_comb begin
		// outputs keep four integer bits above the point
		out_re_nxt = out_map(acc_re_r, aux_re_r, ctrl_r[CTRL_SEL_LO +: 2], ctrl_r[CTRL_FMT]);
		out_im_nxt = out_map(acc_im_r, aux_im_r, ctrl_r[CTRL_SEL_LO +: 2], ctrl_r[CTRL_FMT]);
		grow_now = max2(max2(growth_of(acc_re_r[34:30]), growth_of(acc_im_r[34:30])),
			max2(growth_of(aux_re_r[19:15]), growth_of(aux_im_r[19:15])));
		grow_nxt = grow_now;
		if (!ctrl_r[CTRL_PEAK_N]) begin
			grow_nxt = max2(grow_r, grow_now);
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			out_re_r <= '0;
			out_im_r <= '0;
			grow_r   <= '0;
		end else if (i_clk_en) begin
			out_re_r <= out_re_nxt;
			out_im_r <= out_im_nxt;
			grow_r   <= grow_nxt;
		end
	end

	assign o_real_result  = out_re_r;
	assign o_imag_result  = out_im_r;
	assign o_growth_level = grow_r;

endmodule

// File: verilog/scm_pkg.sv
// constants and helpers shared by the sine/cosine complex multiply-accumulate block
package scm_pkg;
	localparam int PHASE_W    = 32;
	localparam int LUT_ADDR_W = 20;
	localparam int TRIG_W     = 16;
	localparam int IN_W       = 19;
	localparam int PROD_W     = 33;
	localparam int ACC_W      = 35;
	localparam int OUT_W      = 20;
	localparam int AUX_W      = 20;
	localparam int GROW_W     = 2;
	localparam int ADDR_W     = 12;
	localparam int DATA_W     = 32;
	localparam int LATENCY    = 5;

	// register map
	localparam logic [ADDR_W-1:0] CTRL_OFFS = 12'h000;
	localparam logic [ADDR_W-1:0] STAT_OFFS = 12'h004;

	// control register fields
	localparam int CTRL_W         = 7;
	localparam int CTRL_BYPASS_N  = 0;
	localparam int CTRL_SHIFT_LO  = 1;
	localparam int CTRL_SEL_LO    = 3;
	localparam int CTRL_FMT       = 5;
	localparam int CTRL_PEAK_N    = 6;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h61;

	// status register fields
	localparam int STAT_GROW_LO = 0;

	// result select codes
	localparam logic [1:0] SEL_PROD_HI = 2'h0;
	localparam logic [1:0] SEL_PROD_LO = 2'h1;
	localparam logic [1:0] SEL_AUX     = 2'h2;

	// sine/cosine limits, symmetric about zero
	localparam logic [TRIG_W-1:0] TRIG_POS_FS = 16'h7FFF;
	localparam logic [TRIG_W-1:0] TRIG_NEG_FS = 16'h8001;

	// rotation engine used to fill the sine/cosine lookup
	localparam int CORDIC_ITER = 20;
	localparam int ANG_W       = 24;
	localparam int CORDIC_W    = 26;
	localparam int CORDIC_FRAC = 8;

	typedef logic [ANG_W-1:0] scm_ang_tab_t [CORDIC_ITER];

	function automatic scm_ang_tab_t scm_atan_table();
		scm_ang_tab_t t;
		for (int i = 0; i < CORDIC_ITER; i++) begin
			t[i] = ANG_W'($rtoi($atan($pow(2.0, -i)) / (2.0 * 3.14159265358979)
				* $pow(2.0, ANG_W) + 0.5));
		end
		return t;
	endfunction

	function automatic int scm_start_x();
		real k;
		k = 1.0;
		for (int i = 0; i < CORDIC_ITER; i++) begin
			k = k / $sqrt(1.0 + $pow(2.0, -2 * i));
		end
		return $rtoi(k * 32767.0 * $pow(2.0, CORDIC_FRAC) + 0.5);
	endfunction

	localparam scm_ang_tab_t ATAN_TAB = scm_atan_table();
	localparam logic signed [CORDIC_W-1:0] CORDIC_X0 = CORDIC_W'(scm_start_x());
endpackage

// File: sim/scm_phase_src.sv
// upstream phase word source
`timescale 1ns/10ps
module scm_phase_src
	import scm_pkg::*;
(
	input	wire logic			i_clock,
	input	wire logic			i_rst_n,
	input	wire logic			i_load,
	input	wire logic [PHASE_W-1:0]	i_value,
	input	wire logic [PHASE_W-1:0]	i_step,
	output	logic [PHASE_W-1:0]		o_phase_word
);
	logic [PHASE_W-1:0]	phase_r;
	logic [PHASE_W-1:0]	phase_nxt;
	always_comb begin
		phase_nxt = i_load ? i_value : phase_r + i_step;
	end
	always_ff @(posedge i_clock) begin
		phase_r <= !i_rst_n ? '0 : phase_nxt;
	end
	assign o_phase_word = phase_r;
endmodule

// File: sim/scm_top_props.sv
// port checker for the multiply-accumulate block
`timescale 1ns/10ps
module scm_top_props
	import scm_pkg::*;
(
	input	wire logic			i_clock,
	input	wire logic			i_rst_n,
	input	wire logic			i_clk_en,
	input	wire logic			i_psel,
	input	wire logic			i_penable,
	input	wire logic			i_pwrite,
	input	wire logic [ADDR_W-1:0]		i_paddr,
	input	wire logic [DATA_W-1:0]		i_pwdata,
	input	wire logic			o_pslverr,
	input	wire logic [PHASE_W-1:0]	i_phase_word,
	input	wire logic [IN_W-1:0]		i_real_in,
	input	wire logic [IN_W-1:0]		i_imag_in,
	input	wire logic			i_input_capture_en_n,
	input	wire logic			i_accumulate_en,
	input	wire logic [OUT_W-1:0]		o_real_result,
	input	wire logic [OUT_W-1:0]		o_imag_result,
	input	wire logic [GROW_W-1:0]		o_growth_level
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	logic [CTRL_W-1:0]	ctl_r;
	logic [CTRL_W-1:0]	ctl_nxt;
	logic			en;
	// shadow of the control register
	always_comb begin
		ctl_nxt = ctl_r;
		if (i_psel && i_penable && i_pwrite && i_clk_en && i_paddr == CTRL_OFFS)
			ctl_nxt = i_pwdata[CTRL_W-1:0];
	end
	always_ff @(posedge i_clock) begin
		ctl_r <= !i_rst_n ? CTRL_RESET : ctl_nxt;
	end
	assign en = i_clk_en && ctl_r == 7'h60;
	function automatic logic [1:0] gc(input logic [4:0] b);
		return (b == 5'h00 || b == 5'h1F) ? 2'h0 : (b[4:1] == 4'h0 || b[4:1] == 4'hF) ? 2'h1 :
			(b[4:2] == 3'h0 || b[4:2] == 3'h7) ? 2'h2 : 2'h3;
	endfunction
	function automatic logic [19:0] byp(input logic [31:0] w, input logic hi);
		logic signed [34:0]	p;
		p = $signed(hi ? w[31:16] : w[15:0]) * 35'sh07FFF;
		return p[34:15];
	endfunction
	property p_slverr;
		i_psel && i_penable |-> o_pslverr == (i_paddr != CTRL_OFFS && i_paddr != STAT_OFFS);
	endproperty
	a_slverr: assert property (p_slverr) else $error("bad error response");
	property p_bypass;
		(en && !i_input_capture_en_n && i_real_in == 19'h07FFF && i_imag_in == '0) ##1 en [*2]
		##1 (en && !i_accumulate_en) ##1 en |=> o_imag_result == byp($past(i_phase_word, 5), 1)
		&& o_real_result == byp($past(i_phase_word, 5), 0);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass result wrong");
	property p_freeze;
		!i_clk_en |=> $stable(o_real_result) && $stable(o_imag_result) && $stable(o_growth_level);
	endproperty
	a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
	property p_peak;
		!$past(ctl_r[CTRL_PEAK_N]) && $past(i_rst_n) |-> o_growth_level >= $past(o_growth_level);
	endproperty
	a_peak: assert property (p_peak) else $error("growth dropped in hold");
	property p_grow;
		$past(ctl_r[5:3]) == 3'h4 && $past(i_rst_n) && $past(i_clk_en) |->
		o_growth_level >= gc(o_real_result[19:15]) && o_growth_level >= gc(o_imag_result[19:15]);
	endproperty
	a_grow: assert property (p_grow) else $error("growth code too small");
	property p_fmt;
		$past(ctl_r[5:3]) == 3'h0 && $past(i_rst_n) && $past(i_clk_en) |->
		o_growth_level >= gc({~o_real_result[19], o_real_result[18:15]});
	endproperty
	a_fmt: assert property (p_fmt) else $error("unsigned top bit wrong");
	property p_sel_lo;
		$past(ctl_r[4:3]) == 2'h1 && $past(i_rst_n) && $past(i_clk_en) |->
		!o_real_result[15] && !o_imag_result[15];
	endproperty
	a_sel_lo: assert property (p_sel_lo) else $error("gap bit not zero");
	property p_rsvd;
		$past(ctl_r[4:3]) == 2'h3 && $past(i_rst_n) && $past(i_clk_en) |->
		o_real_result == {~$past(ctl_r[5]), 19'h0} && o_imag_result == {~$past(ctl_r[5]), 19'h0};
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved select not zero");
	c_bypass: cover property (en ##1 en ##1 en);
	c_accum: cover property (i_accumulate_en ##1 i_accumulate_en);
	c_hold: cover property (!ctl_r[CTRL_PEAK_N] && o_growth_level == 2'h2);
endmodule
bind scm_top scm_top_props u_scm_top_props (.i_clock, .i_rst_n, .i_clk_en, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .o_pslverr, .i_phase_word, .i_real_in, .i_imag_in,
	.i_input_capture_en_n, .i_accumulate_en, .o_real_result, .o_imag_result, .o_growth_level);

// File: sim/scm_top_tb.sv
// self-checking bench for the multiply-accumulate block
`timescale 1ns/10ps
module scm_top_tb
	import scm_pkg::*;
;
	logic			clk = 0, rst_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic			cap_n = 0, acc = 0, load = 1, pready, pslverr, err;
	logic [ADDR_W-1:0]	paddr = '0;
	logic [DATA_W-1:0]	pwdata = '0, prdata, rd, ct;
	logic [PHASE_W-1:0]	phase, val = '0, step = '0;
	logic [IN_W-1:0]	re = '0, im = '0;
	logic [OUT_W-1:0]	rr, ir;
	logic [GROW_W-1:0]	gl;
	logic [31:0]		phs [4] = '{32'h12345678, 32'h80017FFF, 32'hFFFF8000, 32'h7FFF8001};
	logic [31:0]		tph [5] = '{32'h0, 32'h2AAAAAAA, 32'h40000000, 32'h98765432, 32'hC0000FFF};
	int			bad_count = 0, n_compared = 0;
	real			ang;
	always #2.5 clk = ~clk;
	scm_phase_src u_scm_phase_src (.i_clock(clk), .i_rst_n(rst_n), .i_load(load),
		.i_value(val), .i_step(step), .o_phase_word(phase));
	scm_top u_scm_top (.i_clock(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_phase_word(phase),
		.i_real_in(re), .i_imag_in(im), .i_input_capture_en_n(cap_n), .i_accumulate_en(acc),
		.o_real_result(rr), .o_imag_result(ir), .o_growth_level(gl));
	task automatic check(input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task automatic mac(input logic [31:0] ph, input logic [IN_W-1:0] r, i, input logic a, int n);
		val <= ph;
		re <= r;
		im <= i;
		acc <= a;
		repeat (n) @(posedge clk);
	endtask
	function automatic logic [19:0] res(input logic signed [15:0] s, c, x, y, input int n,
			input logic ims);
		logic signed [34:0]	a;
		logic signed [19:0]	u;
		logic signed [19:0]	r;
		a = ims ? c * y + s * x : c * x - s * y;
		a = a * n;
		u = ims ? y : x;
		u = u * n;
		case (ct[4:3])
			2'h0: r = a[34:15];
			2'h1: r = {a[34:31], 1'b0, a[14:0]};
			2'h2: r = u;
			default: r = '0;
		endcase
		return {r[19] ^ !ct[5], r[18:0]};
	endfunction
	task automatic cmp(input logic [15:0] s, c, x, y, input int n, input logic tol);
		logic signed [19:0]	dr;
		logic signed [19:0]	di;
		dr = rr - res(s, c, x, y, n, 0);
		di = ir - res(s, c, x, y, n, 1);
		if (tol) begin
			check(32'(dr >= -2 && dr <= 2 && di >= -2 && di <= 2), 1);
		end else begin
			check(rr, res(s, c, x, y, n, 0));
			check(ir, res(s, c, x, y, n, 1));
		end
	endtask
	function automatic logic [15:0] q(input real v);
		return 16'($rtoi($floor(v * 32767.0 + 0.5)));
	endfunction
	task summarize;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		apb(0, CTRL_OFFS, 0);
		check(rd, 32'h61);
		apb(1, STAT_OFFS, '1);
		apb(0, STAT_OFFS, 0);
		check({rd[30:0], err}, 0);
		apb(1, 12'h008, '1);
		check({rd[30:0], err}, 1);
		apb(1, CTRL_OFFS, '1);
		apb(0, CTRL_OFFS, 0);
		check(rd, 32'h7F);
		ct = 32'h60;
		apb(1, CTRL_OFFS, ct);
		foreach (phs[j]) begin
			mac(phs[j], 19'h07FFF, 0, 0, 8);
			cmp(phs[j][31:16], phs[j][15:0], 16'h7FFF, 0, 1, 0);
		end
		load <= 0;
		step <= 32'h01010101;
		repeat (20) @(posedge clk);
		load <= 1;
		mac(32'h00007FFF, 19'h07FFF, 19'h00100, 0, 8);
		cap_n <= 1;
		mac(32'h00007FFF, 19'h00123, 19'h40000, 0, 8);
		cmp(0, 16'h7FFF, 16'h7FFF, 16'h0100, 1, 0);
		cap_n <= 0;
		for (int k = 0; k < 16; k++) begin
			ct = {25'h0, 1'b1, k[0], k[3:2], k[1:0], 1'b0};
			apb(1, CTRL_OFFS, ct);
			mac(32'h6ED95A3C, 19'h5A5A5, 19'h3C3C3, 0, 8);
			cmp(16'h6ED9, 16'h5A3C, 16'(19'h5A5A5 >> k[1:0]), 16'(19'h3C3C3 >> k[1:0]), 1,
				0);
		end
		for (int k = 0; k < 2; k++) begin
			ct = k ? 32'h30 : 32'h20;
			apb(1, CTRL_OFFS, ct);
			mac(32'h00007FFF, 19'h07FFF, 19'h78001, 0, 8);
			mac(32'h00007FFF, 19'h07FFF, 19'h78001, 1, 3);
			acc <= 0;
			@(posedge clk);
			clk_en <= 0;
			repeat (4) @(posedge clk);
			check(pready, 1'b0);
			cmp(0, 16'h7FFF, 16'h7FFF, 16'h8001, 4, 0);
			check(gl, 2'h2);
			clk_en <= 1;
			mac(0, 19'h00010, 0, 0, 8);
			check(gl, 2'h2);
		end
		ct = 32'h61;
		apb(1, CTRL_OFFS, ct);
		@(posedge clk);
		check(gl, 2'h0);
		foreach (tph[j]) begin
			ang = 6.283185307179586 * tph[j][31:12] / 1048576.0;
			mac(tph[j], 19'h78001, 0, 0, 8);
			cmp(q($sin(ang)), q($cos(ang)), 16'h8001, 0, 1, 1);
		end
		summarize();
	end
endmodule
